// ===== verilog/eec_pkg.sv
// constants and types shared by the serial memory client
package eec_pkg;

    // control byte device-type code; the value is arbitrary
    localparam logic [3:0] EEC_CTRL_CODE   = 4'h6;
    // control byte fields
    localparam int         EEC_CODE_MSB    = 7;
    localparam int         EEC_CODE_LSB    = 4;
    localparam int         EEC_CS_MSB      = 3;
    localparam int         EEC_CS_LSB      = 1;
    localparam int         EEC_RW_BIT      = 0;
    localparam logic       EEC_RW_READ     = 1'b1;

    // array geometry
    localparam int         EEC_ADDR_W      = 8;
    localparam int         EEC_ARRAY_DEPTH = 256;
    localparam int         EEC_PAGE_MAX    = 16;
    localparam int         EEC_IDX_W       = 4;
    localparam logic [7:0] EEC_MASK_CASC   = 8'h0F;
    localparam logic [7:0] EEC_MASK_PLAIN  = 8'h07;
    localparam int         EEC_PROT_BIT    = 7;

    // bits per byte, counted on clock rises
    localparam logic [3:0] EEC_BITS_BYTE   = 4'h8;

    // write cycle time
    localparam longint     EEC_CLK_HZ      = 20_000_000;
    localparam longint     EEC_TWC_MS      = 5;
    localparam int         EEC_TWC_CYC     = int'((EEC_TWC_MS * EEC_CLK_HZ) / 1000);

    // reset values
    localparam logic [7:0] EEC_PTR_RST     = 8'h00;
    localparam logic [7:0] EEC_BYTE_RST    = 8'h00;

    // sampled bus lines travel together
    typedef struct packed {
        logic scl;
        logic sda;
    } eec_lines_t;

    typedef enum {
        EEC_ST_IDLE,
        EEC_ST_CTRL,
        EEC_ST_ADDR,
        EEC_ST_WDATA,
        EEC_ST_RDATA,
        EEC_ST_IGNORE
    } eec_state_t;

endpackage : eec_pkg

// ===== verilog/eec_client.sv
// serial memory client: bus decode, addressing, page write and read
`timescale 1ns/1ps

module eec_client
    import eec_pkg::*;
#(
    parameter bit CASCADE         = 1'b1,
    parameter int WRITE_CYCLE_CYC = EEC_TWC_CYC
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_out,
    input  wire logic chip_sel_in_0,
    input  wire logic chip_sel_in_1,
    input  wire logic chip_sel_in_2,
    output logic      busy_out
);

    localparam int         TMR_W     = $clog2(WRITE_CYCLE_CYC + 1);
    localparam logic [7:0] PAGE_MASK = CASCADE ? EEC_MASK_CASC : EEC_MASK_PLAIN;

    eec_lines_t       sync1_r;
    eec_lines_t       sync2_r;
    eec_lines_t       sync3_r;
    eec_lines_t       filt_r;
    eec_lines_t       prev_r;

    eec_state_t       state_r;
    logic [3:0]       bit_cnt_r;
    logic             ack_phase_r;
    logic [7:0]       shift_r;
    logic [7:0]       tx_r;
    logic [7:0]       ptr_r;
    logic [7:0]       wbase_r;
    logic             sda_oe_r;
    logic             sda_o_r;
    logic             host_ack_r;
    logic [EEC_PAGE_MAX-1:0] valid_r;
    logic [2:0]       strap_s1_r;
    logic [2:0]       strap_s2_r;
    logic [2:0]       strap_s3_r;
    logic [2:0]       strap_r;
    logic             busy_r;
    logic [TMR_W-1:0] timer_r;

    logic [7:0]       page_buf [EEC_PAGE_MAX];
    logic [7:0]       mem      [EEC_ARRAY_DEPTH];

    logic             start_det;
    logic             stop_det;
    logic             scl_rise;
    logic             scl_fall;
    logic             byte_done;
    logic             ack_end;
    logic             ctrl_match;
    logic             buf_we;
    logic [EEC_IDX_W-1:0] wr_idx;
    logic [EEC_IDX_W-1:0] cm_idx;
    logic [7:0]       cm_addr;
    logic [7:0]       ptr_page_nxt;

    // three stages; a level counts once stages two and three agree
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_r <= '{scl: 1'b1, sda: 1'b1};
            sync2_r <= '{scl: 1'b1, sda: 1'b1};
            sync3_r <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            sync1_r <= '{scl: scl_in, sda: sda_in};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            filt_r <= '{scl: 1'b1, sda: 1'b1};
            prev_r <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            if (sync2_r.scl == sync3_r.scl) begin
                filt_r.scl <= sync3_r.scl;
            end
            if (sync2_r.sda == sync3_r.sda) begin
                filt_r.sda <= sync3_r.sda;
            end
            // one clock behind the filter, for edge detection
            prev_r <= filt_r;
        end
    end

    // straps are pins too: same three stages and agree filter as the bus lines
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_s1_r <= 3'h0;
            strap_s2_r <= 3'h0;
            strap_s3_r <= 3'h0;
            strap_r    <= 3'h0;
        end else begin
            strap_s1_r <= {chip_sel_in_2, chip_sel_in_1, chip_sel_in_0};
            strap_s2_r <= strap_s1_r;
            strap_s3_r <= strap_s2_r;
            if (strap_s2_r == strap_s3_r) begin
                strap_r <= strap_s3_r;
            end
        end
    end

    always_comb begin
        // line events are only meaningful with clock high from before
        start_det = filt_r.scl && prev_r.scl && prev_r.sda && !filt_r.sda;
        stop_det  = filt_r.scl && prev_r.scl && !prev_r.sda && filt_r.sda;
        scl_rise  = filt_r.scl && !prev_r.scl;
        scl_fall  = !filt_r.scl && prev_r.scl;
        byte_done = scl_fall && !ack_phase_r && (bit_cnt_r == EEC_BITS_BYTE);
        ack_end   = scl_fall && ack_phase_r;
        ctrl_match = (shift_r[EEC_CODE_MSB:EEC_CODE_LSB] == EEC_CTRL_CODE)
                  && (!CASCADE || (shift_r[EEC_CS_MSB:EEC_CS_LSB] == strap_r))
                  && !busy_r;
        buf_we    = byte_done && (state_r == EEC_ST_WDATA);
        wr_idx    = ptr_r[EEC_IDX_W-1:0] & PAGE_MASK[EEC_IDX_W-1:0];
        ptr_page_nxt = (ptr_r & ~PAGE_MASK) | ((ptr_r + 8'h01) & PAGE_MASK);
        cm_idx    = timer_r[EEC_IDX_W-1:0];
        cm_addr   = (wbase_r & ~PAGE_MASK) | {{(8 - EEC_IDX_W){1'b0}}, cm_idx};
    end

    // protocol engine: bit counting, acknowledge, address and read data
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r     <= EEC_ST_IDLE;
            bit_cnt_r   <= 4'h0;
            ack_phase_r <= 1'b0;
            shift_r     <= EEC_BYTE_RST;
            tx_r        <= EEC_BYTE_RST;
            ptr_r       <= EEC_PTR_RST;
            wbase_r     <= EEC_PTR_RST;
            sda_oe_r    <= 1'b0;
            host_ack_r  <= 1'b0;
            valid_r     <= '0;
        end else if (start_det) begin
            // repeated start drops an uncommitted page, keeps the pointer
            state_r     <= EEC_ST_CTRL;
            bit_cnt_r   <= 4'h0;
            ack_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
            // a poll during the write cycle must not drop the page being committed
            if (!busy_r) begin
                valid_r <= '0;
            end
        end else if (stop_det) begin
            state_r     <= EEC_ST_IDLE;
            ack_phase_r <= 1'b0;
            sda_oe_r    <= 1'b0;
        end else if (state_r != EEC_ST_IDLE && state_r != EEC_ST_IGNORE) begin
            if (scl_rise) begin
                if (!ack_phase_r) begin
                    shift_r   <= {shift_r[6:0], filt_r.sda};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end else begin
                    host_ack_r <= !filt_r.sda;
                end
            end else if (byte_done) begin
                ack_phase_r <= 1'b1;
                bit_cnt_r   <= 4'h0;
                case (state_r)
                    EEC_ST_CTRL: begin
                        if (ctrl_match) begin
                            sda_oe_r <= 1'b1;
                            if (shift_r[EEC_RW_BIT] == EEC_RW_READ) begin
                                state_r <= EEC_ST_RDATA;
                            end else begin
                                state_r <= EEC_ST_ADDR;
                            end
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r  <= EEC_ST_IGNORE;
                        end
                    end
                    EEC_ST_ADDR: begin
                        ptr_r    <= shift_r;
                        wbase_r  <= shift_r;
                        valid_r  <= '0;
                        sda_oe_r <= 1'b1;
                        state_r  <= EEC_ST_WDATA;
                    end
                    EEC_ST_WDATA: begin
                        valid_r[wr_idx] <= 1'b1;
                        ptr_r    <= ptr_page_nxt;
                        sda_oe_r <= 1'b1;
                    end
                    EEC_ST_RDATA: begin
                        sda_oe_r <= 1'b0;
                    end
                    default: begin
                        sda_oe_r <= 1'b0;
                    end
                endcase
            end else if (ack_end) begin
                ack_phase_r <= 1'b0;
                // acknowledge ends with the ninth pulse; a read below may drive again
                sda_oe_r    <= 1'b0;
                if (state_r == EEC_ST_RDATA) begin
                    if (host_ack_r) begin
                        // first byte after control ack, or host asked for more
                        tx_r     <= mem[ptr_r];
                        sda_oe_r <= !mem[ptr_r][7];
                        ptr_r    <= ptr_r + 8'h01;
                    end else begin
                        state_r <= EEC_ST_IGNORE;
                    end
                end
                host_ack_r <= 1'b0;
            end else if (scl_fall && state_r == EEC_ST_RDATA) begin
                tx_r     <= {tx_r[6:0], 1'b0};
                sda_oe_r <= !tx_r[6];
            end
            if (byte_done && state_r == EEC_ST_CTRL && ctrl_match
                    && shift_r[EEC_RW_BIT] == EEC_RW_READ) begin
                // control ack counts as the go-ahead for the first byte
                host_ack_r <= 1'b1;
            end
        end
    end

    // page buffer has no reset; entries count only once marked valid
    always_ff @(posedge clk_in) begin
        if (buf_we) begin
            page_buf[wr_idx] <= shift_r;
        end
    end

    // write cycle: commit the buffer, then hold busy for the full time
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_r  <= 1'b0;
            timer_r <= '0;
        end else if (!busy_r) begin
            // a stop with no data byte leaves the array alone
            if (stop_det && state_r == EEC_ST_WDATA && (|valid_r)) begin
                busy_r  <= 1'b1;
                timer_r <= '0;
            end
        end else if (timer_r == TMR_W'(WRITE_CYCLE_CYC - 1)) begin
            busy_r  <= 1'b0;
            timer_r <= '0;
        end else begin
            timer_r <= timer_r + TMR_W'(1);
        end
    end

    // the array itself is not reset
    always_ff @(posedge clk_in) begin
        if (busy_r && timer_r < TMR_W'(EEC_PAGE_MAX) && valid_r[cm_idx]
                && !cm_addr[EEC_PROT_BIT]) begin
            mem[cm_addr] <= page_buf[cm_idx];
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sda_o_r <= 1'b0;
        end else begin
            sda_o_r <= 1'b0;
        end
    end

    // outputs come straight from their flip-flops
    always_comb begin
        sda_out    = sda_o_r;
        sda_oe_out = sda_oe_r;
        busy_out   = busy_r;
    end

endmodule : eec_client

// ===== verification/eec_host_model.sv
// two-wire bus host model: makes the serial clock and pulls the data line
`timescale 1ns/1ps

module eec_host_model (
    input  wire logic clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    initial begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    // 8 cycle bit: data moves 1 cycle into low, clock high for the last 2;
    // the client answers 5 cycles after a fall, so its data settles before the rise
    task automatic bit_xfer(input logic b, output logic seen);
        tick(1);
        sda_oe_out <= ~b;
        tick(5);
        scl_out <= 1'b1;
        tick(2);
        seen = sda_in;
        scl_out <= 1'b0;
    endtask : bit_xfer

    // long low phase lets a trailing acknowledge clear before clock rises
    task automatic start;
        tick(2);
        sda_oe_out <= 1'b0;
        tick(6);
        scl_out <= 1'b1;
        tick(4);
        sda_oe_out <= 1'b1;
        tick(4);
        scl_out <= 1'b0;
    endtask : start

    task automatic stop;
        tick(2);
        sda_oe_out <= 1'b1;
        tick(6);
        scl_out <= 1'b1;
        tick(4);
        sda_oe_out <= 1'b0;
        tick(8);
    endtask : stop

    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
        bit_xfer(1'b1, s);
        ack = ~s;
    endtask : send

    task automatic recv(input logic ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
        bit_xfer(~ack, s);
    endtask : recv
endmodule : eec_host_model

// ===== verification/eec_client_checker.sv
// pin-level assertions for the serial memory client
`timescale 1ns/1ps

module eec_client_checker #(
    parameter bit CASCADE         = 1'b1,
    parameter int WRITE_CYCLE_CYC = 100000
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic chip_sel_in_0,
    input wire logic chip_sel_in_1,
    input wire logic chip_sel_in_2,
    input wire logic busy_out
);
    int busy_cnt_r;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_cnt_r <= 0;
        end else begin
            busy_cnt_r <= busy_out ? busy_cnt_r + 1 : 0;
        end
    end

    default clocking dc @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    chk_open_drain: assert property (sda_oe_out |-> !sda_out)
        else $error("data line driven high");
    // first reset edge skipped: the asynchronous clear may not have fired yet
    chk_reset_quiet: assert property (disable iff (1'b0)
        !rst_n_in && $past(!rst_n_in) |-> !sda_oe_out && !busy_out)
        else $error("outputs active in reset");
    chk_busy_bound: assert property (busy_cnt_r <= WRITE_CYCLE_CYC)
        else $error("write cycle too long");
    chk_busy_min: assert property ($fell(busy_out) |-> busy_cnt_r == WRITE_CYCLE_CYC)
        else $error("write cycle length wrong");
    chk_no_ack_busy: assert property ($rose(sda_oe_out) |-> !busy_out)
        else $error("acknowledge during write cycle");
    chk_busy_at_stop: assert property ($rose(busy_out) |-> scl_in && sda_in)
        else $error("write cycle without stop");
    chk_steady_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
        else $error("data moved while clock high");
    chk_ack_held: assert property ($rose(scl_in) && sda_oe_out |-> sda_oe_out [*3])
        else $error("acknowledge dropped in clock high");
endmodule : eec_client_checker

bind eec_client eec_client_checker #(
    .CASCADE(CASCADE),
    .WRITE_CYCLE_CYC(WRITE_CYCLE_CYC)
) u_chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .chip_sel_in_0(chip_sel_in_0),
    .chip_sel_in_1(chip_sel_in_1), .chip_sel_in_2(chip_sel_in_2), .busy_out(busy_out)
);

// ===== verification/tb_eec_client.sv
// self-checking bench for the serial memory client
`timescale 1ns/1ps

module tb_eec_client
    import eec_pkg::*;
;
    localparam int         WCC = 200;
    localparam logic [7:0] WR  = {EEC_CTRL_CODE, 3'b101, 1'b0};
    localparam logic [7:0] RD  = {EEC_CTRL_CODE, 3'b101, 1'b1};
    typedef struct packed { logic [7:0] c; logic ack; logic [7:0] d; } eec_row_t;
    eec_row_t   rows [4] = '{'{RD, 1'b1, 8'h41}, '{WR, 1'b1, 8'h00},
                             '{{4'hB, 3'b101, 1'b0}, 1'b0, 8'h00},
                             '{{EEC_CTRL_CODE, 3'b001, 1'b0}, 1'b0, 8'h00}};
    logic       clk_in    = 1'b0;
    logic       rst_n_in  = 1'b0;
    logic [2:0] cs        = 3'b101;
    logic       scl, h_oe, so, oe, busy, ack;
    logic [7:0] d;
    wire        sda_w;
    int         n_errors  = 0;
    int         cmp_count = 0;

    always #25 clk_in = ~clk_in;
    // wired-and with pull-up
    assign sda_w = ~(h_oe | (oe & ~so));

    eec_client #(.CASCADE(1'b1), .WRITE_CYCLE_CYC(WCC)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_w),
        .sda_out(so), .sda_oe_out(oe), .chip_sel_in_0(cs[0]), .chip_sel_in_1(cs[1]),
        .chip_sel_in_2(cs[2]), .busy_out(busy));
    eec_host_model host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_oe_out(h_oe));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic ctrl(input logic [7:0] c, input logic exp_ack);
        host.start();
        host.send(c, ack);
        check({7'h00, ack}, {7'h00, exp_ack});
    endtask : ctrl

    task automatic wbyte(input logic [7:0] b);
        host.send(b, ack);
        check({7'h00, ack}, 8'h01);
    endtask : wbyte

    task automatic wait_idle;
        for (int k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk_in);
        check({7'h00, busy}, 8'h00);
    endtask : wait_idle

    initial begin
        repeat (12) @(posedge clk_in);
        check({6'h00, oe, busy}, 8'h00);
        rst_n_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        ctrl(WR, 1'b1);
        wbyte(8'h0F);
        wbyte(8'h5A);
        host.stop();
        check({7'h00, busy}, 8'h01);
        ctrl(WR, 1'b0);
        host.stop();
        wait_idle();
        // 18 bytes from index E: the first two are overwritten by the last two
        ctrl(WR, 1'b1);
        wbyte(8'h1E);
        for (int i = 0; i < 18; i++) wbyte(8'h30 + 8'(i));
        host.stop();
        wait_idle();
        ctrl(WR, 1'b1);
        wbyte(8'h0F);
        ctrl(RD, 1'b1);
        for (int i = 0; i < 16; i++) begin
            host.recv(i < 15, d);
            check(d, i == 0 ? 8'h5A : 8'h31 + 8'(i));
        end
        host.stop();
        foreach (rows[i]) begin
            ctrl(rows[i].c, rows[i].ack);
            if (rows[i].c[0] && rows[i].ack) begin
                host.recv(1'b0, d);
                check(d, rows[i].d);
            end
            host.stop();
        end
        // reset in mid write cycle: busy clears, device answers again
        ctrl(WR, 1'b1);
        wbyte(8'h05);
        wbyte(8'hC3);
        host.stop();
        check({7'h00, busy}, 8'h01);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        check({6'h00, oe, busy}, 8'h00);
        rst_n_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        ctrl(WR, 1'b1);
        host.stop();
        // top strap tied low, as where that pin is missing
        cs <= 3'b001;
        repeat (10) @(posedge clk_in);
        ctrl({EEC_CTRL_CODE, 3'b001, 1'b0}, 1'b1);
        host.stop();
        ctrl(WR, 1'b0);
        host.stop();
        final_report();
    end

    // whole sequence needs well under 1 ms
    initial begin
        #2_000_000;
        n_errors++;
        final_report();
    end
endmodule : tb_eec_client
